// file: verilog/vswm_pkg.sv
// Shared constants, types and helper functions for the slave window map
package vswm_pkg;

	localparam int unsigned CLK_PERIOD_NS = 4;

	// Address map
	localparam logic [31:0] REGION_BYTES = 32'h0004_0000;
	localparam logic [31:0] SLOT_BYTES = 32'h0000_2000;
	localparam logic [5:0] SLOT_COUNT = 6'h20;
	localparam logic [31:0] DEF_REGION_BASE = 32'heffc_0000;
	localparam logic [31:0] PIO_WINDOW_LOW_LIMIT = 32'hc000_0000;
	localparam logic [31:0] PIO_WINDOW_HIGH_LIMIT = 32'hfaff_ffff;
	localparam logic [31:0] DRAM_SPACE_LIMIT = 32'h8000_0000;
	localparam logic [31:0] WIN0_CTRL_VALUE = 32'h80f2_0001;
	localparam logic [31:0] DRAM_WIN_UNIT = 32'h0400_0000;

	// Register bank inside window 0
	localparam logic [10:0] BANK_STATUS_IDX = 11'h000;
	localparam logic [10:0] BANK_WORDS = 11'h004;
	localparam logic [31:0] BANK_RESET = 32'h0000_0000;

	// Timing
	localparam int unsigned STRAP_SETTLE = 3;
	localparam int unsigned PROBE_TIMEOUT_NS = 64;
	localparam int unsigned PROBE_TIMEOUT_CYC = (PROBE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		SZ_64M = 3'h0,
		SZ_128M = 3'h1,
		SZ_256M = 3'h2,
		SZ_512M = 3'h3,
		SZ_1G = 3'h4
	} vswm_size_t;

	function automatic logic [4:0] max_boards(input logic [2:0] sz);
		unique case (sz)
			SZ_1G: max_boards = 5'h02;
			SZ_512M: max_boards = 5'h04;
			SZ_256M: max_boards = 5'h08;
			SZ_128M: max_boards = 5'h10;
			default: max_boards = 5'h15;
		endcase
	endfunction : max_boards

	function automatic logic [31:0] win_bytes(input logic [2:0] sz);
		win_bytes = DRAM_WIN_UNIT << sz;
	endfunction : win_bytes

	function automatic logic [31:0] slot_start(input logic [31:0] base, input logic [4:0] board);
		slot_start = base + {14'h0, board, 13'h0};
	endfunction : slot_start

	function automatic logic [31:0] twos_neg(input logic [31:0] v);
		twos_neg = ~v + 32'h0000_0001;
	endfunction : twos_neg

	// Cluster window choice from the largest fitted memory and the board total
	function automatic logic [2:0] pick_size(input logic [2:0] largest, input logic [4:0] boards);
		if (largest == SZ_1G)
			pick_size = SZ_1G;
		else if (largest == SZ_512M || boards <= 5'h04)
			pick_size = SZ_512M;
		else if (largest == SZ_256M || boards <= 5'h08)
			pick_size = SZ_256M;
		else if (largest == SZ_128M || boards <= 5'h10)
			pick_size = SZ_128M;
		else
			pick_size = SZ_64M;
	endfunction : pick_size

endpackage : vswm_pkg

// file: verilog/vswm_if.sv
// Single-beat A32 access link between a peer bus master and a board
`timescale 1ns/100ps
interface vswm_if;
	logic req;
	logic we;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic ack;
	logic [31:0] rdata;

	modport peer (output req, output we, output addr, output wdata, input ack, input rdata);
	modport board (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface : vswm_if

// file: verilog/vswm_window.sv
// Address comparator and translator for one slave window
`timescale 1ns/100ps
module vswm_window (
	// Window settings
	input wire logic en_in,
	input wire logic [31:0] start_in,
	input wire logic [31:0] bound_in,
	input wire logic [31:0] offset_in,
	// Access
	input wire logic [31:0] addr_in,
	output logic hit_out,
	output logic [31:0] local_out
);
	always_comb begin
		hit_out = en_in && (addr_in >= start_in) && (addr_in < bound_in);
		local_out = addr_in + offset_in;
	end
endmodule : vswm_window

// file: verilog/vswm_board_end.sv
// Board end: two slave windows, register bank and DRAM forwarding
`timescale 1ns/100ps
module vswm_board_end (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Link
	vswm_if.board bus,
	// Straps
	input wire logic [4:0] board_num_in,
	input wire logic [2:0] win_size_in,
	input wire logic [31:0] region_base_in,
	// Local DRAM port
	output logic mem_req_out,
	output logic mem_we_out,
	output logic [31:0] mem_addr_out,
	output logic [31:0] mem_wdata_out,
	input wire logic [31:0] mem_rdata_in,
	// Configuration status
	output logic cfg_ready_out,
	output logic cfg_err_out,
	output logic [31:0] win0_ctrl_out,
	output logic [31:0] win0_start_out,
	output logic [31:0] win0_bound_out,
	output logic [31:0] win0_offset_out,
	output logic win0_en_out,
	output logic [31:0] win1_start_out,
	output logic [31:0] win1_bound_out,
	output logic win1_en_out
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_MEM = 2'h1,
		ST_CAP = 2'h2
	} vswm_state_t;

	logic [39:0] strap_s1_q;
	logic [39:0] strap_s2_q;
	logic [1:0] settle_q;
	logic cfg_ready_q;
	logic cfg_err_q;
	logic [4:0] board_q;
	logic [2:0] size_q;
	logic [31:0] w0_start_q;
	logic [31:0] w0_bound_q;
	logic [31:0] w0_offset_q;
	logic w0_en_q;
	logic [31:0] w1_start_q;
	logic [31:0] w1_bound_q;
	logic [31:0] w1_offset_q;
	logic w1_en_q;
	vswm_state_t state_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic mem_req_q;
	logic mem_we_q;
	logic [31:0] mem_addr_q;
	logic [31:0] mem_wdata_q;
	logic [31:0] bank_q [1:3];

	logic hit0;
	logic hit1;
	logic [31:0] local0;
	logic [31:0] local1;
	logic [10:0] bank_idx;
	logic take;

	// Straps come from pins: two flops before use
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			strap_s1_q <= 40'h00_0000_0000;
			strap_s2_q <= 40'h00_0000_0000;
		end else begin
			strap_s1_q <= {region_base_in, win_size_in, board_num_in};
			strap_s2_q <= strap_s1_q;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			settle_q <= 2'h0;
		else if (settle_q != 2'(vswm_pkg::STRAP_SETTLE))
			settle_q <= settle_q + 2'h1;
	end

	// Settings are computed once; straps are not meant to move while running
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		logic [31:0] base;
		logic [4:0] bn;
		logic [2:0] sz;
		logic [31:0] s0;
		logic [31:0] s1;
		logic ok0;
		logic ok1;
		if (!resetn_in) begin
			cfg_ready_q <= 1'b0;
			cfg_err_q <= 1'b0;
			board_q <= 5'h00;
			size_q <= 3'h0;
			w0_start_q <= 32'h0000_0000;
			w0_bound_q <= 32'h0000_0000;
			w0_offset_q <= 32'h0000_0000;
			w0_en_q <= 1'b0;
			w1_start_q <= 32'h0000_0000;
			w1_bound_q <= 32'h0000_0000;
			w1_offset_q <= 32'h0000_0000;
			w1_en_q <= 1'b0;
		end else if (!cfg_ready_q && settle_q == 2'(vswm_pkg::STRAP_SETTLE)) begin
			base = strap_s2_q[39:8];
			sz = strap_s2_q[7:5];
			bn = strap_s2_q[4:0];
			s0 = vswm_pkg::slot_start(base, bn);
			s1 = 32'({27'h0, bn} * vswm_pkg::win_bytes(sz));
			// Region must be aligned and wholly inside the I/O window
			ok0 = (base[17:0] == 18'h0) && (base >= vswm_pkg::PIO_WINDOW_LOW_LIMIT) &&
				(base <= vswm_pkg::PIO_WINDOW_HIGH_LIMIT - vswm_pkg::REGION_BYTES + 32'h1);
			ok1 = (sz <= 3'(vswm_pkg::SZ_1G)) && (bn < vswm_pkg::max_boards(sz));
			cfg_ready_q <= 1'b1;
			cfg_err_q <= !(ok0 && ok1);
			board_q <= bn;
			size_q <= sz;
			w0_start_q <= s0;
			w0_bound_q <= s0 + vswm_pkg::SLOT_BYTES;
			w0_offset_q <= vswm_pkg::twos_neg(s0);
			w0_en_q <= ok0;
			w1_start_q <= s1;
			w1_bound_q <= s1 + vswm_pkg::win_bytes(sz);
			w1_offset_q <= vswm_pkg::twos_neg(s1);
			w1_en_q <= ok1 && (s1 + vswm_pkg::win_bytes(sz) <= vswm_pkg::DRAM_SPACE_LIMIT);
		end
	end

	vswm_window u_win0 (
		.en_in(w0_en_q),
		.start_in(w0_start_q),
		.bound_in(w0_bound_q),
		.offset_in(w0_offset_q),
		.addr_in(bus.addr),
		.hit_out(hit0),
		.local_out(local0)
	);

	vswm_window u_win1 (
		.en_in(w1_en_q),
		.start_in(w1_start_q),
		.bound_in(w1_bound_q),
		.offset_in(w1_offset_q),
		.addr_in(bus.addr),
		.hit_out(hit1),
		.local_out(local1)
	);

	assign take = bus.req && cfg_ready_q && (state_q == ST_IDLE);
	assign bank_idx = local0[12:2];

	// Access sequencer; a miss is dropped silently for other slaves
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			state_q <= ST_IDLE;
		else begin
			unique case (state_q)
				ST_IDLE: if (take && !hit0 && hit1) state_q <= ST_MEM;
				ST_MEM: state_q <= ST_CAP;
				ST_CAP: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= 1'b0;
			if (take && hit0) begin
				ack_q <= 1'b1;
				if (bus.we)
					rdata_q <= 32'h0000_0000;
				else if (bank_idx == vswm_pkg::BANK_STATUS_IDX)
					rdata_q <= {cfg_err_q, 23'h0, size_q, board_q};
				else if (bank_idx < vswm_pkg::BANK_WORDS)
					rdata_q <= bank_q[bank_idx[1:0]];
				else
					rdata_q <= 32'h0000_0000;
			end else if (state_q == ST_CAP) begin
				ack_q <= 1'b1;
				rdata_q <= mem_we_q ? 32'h0000_0000 : mem_rdata_in;
			end
		end
	end

	// Scratch words 1..3; word 0 is read-only status
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bank_q[1] <= vswm_pkg::BANK_RESET;
			bank_q[2] <= vswm_pkg::BANK_RESET;
			bank_q[3] <= vswm_pkg::BANK_RESET;
		end else if (take && hit0 && bus.we && bank_idx != vswm_pkg::BANK_STATUS_IDX &&
				bank_idx < vswm_pkg::BANK_WORDS) begin
			bank_q[bank_idx[1:0]] <= bus.wdata;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_addr_q <= 32'h0000_0000;
			mem_wdata_q <= 32'h0000_0000;
		end else begin
			mem_req_q <= 1'b0;
			if (take && !hit0 && hit1) begin
				mem_req_q <= 1'b1;
				mem_we_q <= bus.we;
				mem_addr_q <= local1;
				mem_wdata_q <= bus.wdata;
			end
		end
	end

	assign bus.ack = ack_q;
	assign bus.rdata = rdata_q;
	assign mem_req_out = mem_req_q;
	assign mem_we_out = mem_we_q;
	assign mem_addr_out = mem_addr_q;
	assign mem_wdata_out = mem_wdata_q;
	assign cfg_ready_out = cfg_ready_q;
	assign cfg_err_out = cfg_err_q;
	assign win0_start_out = w0_start_q;
	assign win0_bound_out = w0_bound_q;
	assign win0_offset_out = w0_offset_q;
	assign win0_en_out = w0_en_q;
	assign win1_start_out = w1_start_q;
	assign win1_bound_out = w1_bound_q;
	assign win1_en_out = w1_en_q;

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			win0_ctrl_out <= 32'h0000_0000;
		else
			win0_ctrl_out <= vswm_pkg::WIN0_CTRL_VALUE;
	end

endmodule : vswm_board_end

// file: verilog/vswm_peer_end.sv
// Peer master end: single accesses, slot probe and cluster sizing
`timescale 1ns/100ps
module vswm_peer_end (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Link
	vswm_if.peer bus,
	// Single access port
	input wire logic cmd_req_in,
	input wire logic cmd_we_in,
	input wire logic [31:0] cmd_addr_in,
	input wire logic [31:0] cmd_wdata_in,
	output logic cmd_done_out,
	output logic cmd_miss_out,
	output logic [31:0] cmd_rdata_out,
	// Slot probe
	input wire logic probe_start_in,
	input wire logic [31:0] probe_base_in,
	output logic probe_busy_out,
	output logic [31:0] present_out,
	// Cluster sizing
	input wire logic [2:0] largest_dram_in,
	input wire logic [4:0] board_total_in,
	input wire logic [4:0] own_num_in,
	input wire logic first_slot_in,
	output logic [2:0] win_size_out,
	output logic own_num_ok_out
);

	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_WAIT = 2'h1,
		H_NEXT = 2'h2
	} vswm_hstate_t;

	vswm_hstate_t state_q;
	logic req_q;
	logic we_q;
	logic [31:0] addr_q;
	logic [31:0] wdata_q;
	logic [4:0] timer_q;
	logic probing_q;
	logic [4:0] slot_q;
	logic [31:0] base_q;
	logic [31:0] present_q;
	logic done_q;
	logic miss_q;
	logic [31:0] rdata_q;
	logic [2:0] size_q;
	logic num_ok_q;
	logic timeout;

	localparam int unsigned PROBE_TIMEOUT_CYC_L = vswm_pkg::PROBE_TIMEOUT_CYC;
	assign timeout = (timer_q == 5'(PROBE_TIMEOUT_CYC_L));

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q <= H_IDLE;
			req_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= 32'h0000_0000;
			wdata_q <= 32'h0000_0000;
			timer_q <= 5'h00;
			probing_q <= 1'b0;
			slot_q <= 5'h00;
			base_q <= vswm_pkg::DEF_REGION_BASE;
			present_q <= 32'h0000_0000;
			done_q <= 1'b0;
			miss_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			req_q <= 1'b0;
			done_q <= 1'b0;
			unique case (state_q)
				H_IDLE: begin
					if (probe_start_in) begin
						probing_q <= 1'b1;
						slot_q <= 5'h00;
						base_q <= probe_base_in;
						present_q <= 32'h0000_0000;
						req_q <= 1'b1;
						we_q <= 1'b0;
						addr_q <= probe_base_in;
						timer_q <= 5'h00;
						state_q <= H_WAIT;
					end else if (cmd_req_in) begin
						req_q <= 1'b1;
						we_q <= cmd_we_in;
						addr_q <= cmd_addr_in;
						wdata_q <= cmd_wdata_in;
						timer_q <= 5'h00;
						state_q <= H_WAIT;
					end
				end
				H_WAIT: begin
					timer_q <= timer_q + 5'h01;
					// A silent bus means no board owns the address
					if (bus.ack || timeout) begin
						if (probing_q) begin
							present_q[slot_q] <= bus.ack;
							state_q <= H_NEXT;
						end else begin
							done_q <= 1'b1;
							miss_q <= !bus.ack;
							rdata_q <= bus.ack ? bus.rdata : 32'h0000_0000;
							state_q <= H_IDLE;
						end
					end
				end
				H_NEXT: begin
					if (slot_q == 5'(vswm_pkg::SLOT_COUNT - 6'h01)) begin
						probing_q <= 1'b0;
						state_q <= H_IDLE;
					end else begin
						slot_q <= slot_q + 5'h01;
						req_q <= 1'b1;
						addr_q <= vswm_pkg::slot_start(base_q, slot_q + 5'h01);
						timer_q <= 5'h00;
						state_q <= H_WAIT;
					end
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			size_q <= 3'h0;
			num_ok_q <= 1'b0;
		end else begin
			size_q <= vswm_pkg::pick_size(largest_dram_in, board_total_in);
			num_ok_q <= first_slot_in ? (own_num_in == 5'h00) :
				(own_num_in != 5'h00 && own_num_in < vswm_pkg::max_boards(size_q));
		end
	end

	assign bus.req = req_q;
	assign bus.we = we_q;
	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;
	assign cmd_done_out = done_q;
	assign cmd_miss_out = miss_q;
	assign cmd_rdata_out = rdata_q;
	assign probe_busy_out = probing_q;
	assign present_out = present_q;
	assign win_size_out = size_q;
	assign own_num_ok_out = num_ok_q;

endmodule : vswm_peer_end

// file: sim/vswm_props.sv
// Link checks between the peer end and the board end
`timescale 1ns/100ps
module vswm_props #(
	parameter logic [31:0] W0_START = 32'heffc_6000,
	parameter logic [31:0] W1_START = 32'h3000_0000,
	parameter logic [31:0] W1_BOUND = 32'h4000_0000
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Link
	input wire logic req,
	input wire logic we,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic ack,
	input wire logic [31:0] rdata
);
	logic in0;
	logic in1;
	assign in0 = addr >= W0_START && addr < W0_START + 32'h0000_2000;
	assign in1 = addr >= W1_START && addr < W1_BOUND;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!resetn_in);
	a_reg_slot_ack: assert property (req && in0 |=> ack)
		else $error("register slot access not answered next cycle");
	a_dram_ack_late: assert property (req && in1 && !in0 |=> !ack ##1 !ack ##1 ack)
		else $error("memory window answer not on third cycle");
	a_outside_no_ack: assert property (req && !in0 && !in1 |=> !ack [*4])
		else $error("access outside own windows was claimed");
	a_ack_one_cycle: assert property (ack |=> !ack)
		else $error("answer longer than one cycle");
	a_ack_has_cause: assert property (ack |-> $past(req) || $past(req, 3))
		else $error("answer without matching request");
	a_req_one_cycle: assert property (req |=> !req)
		else $error("request longer than one cycle");
	a_high_idx_zero: assert property (req && !we && in0 && addr[12:2] >= 11'h004 |=> rdata == 32'h0)
		else $error("unused register word read nonzero");
	a_write_rdata_zero: assert property (req && we && (in0 || in1) ##[1:3] ack |-> rdata == 32'h0)
		else $error("write answer carried data");
	logic unused_wdata;
	assign unused_wdata = ^wdata;
endmodule : vswm_props

// file: sim/vme_slave_window_map_tb.sv
// Bench joining a peer end and a board end across the link
`timescale 1ns/100ps
module vme_slave_window_map_tb;
	logic mclk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [4:0] brd_num = 5'h03;
	logic [2:0] brd_sz = 3'h2;
	logic [31:0] brd_base = 32'heffc_0000;
	logic mem_req, mem_we, cfg_ready, cfg_err, w0_en, w1_en;
	logic [31:0] mem_addr, mem_wdata, w0_ctrl, w0_start, w0_bound, w0_off, w1_start, w1_bound;
	logic [31:0] dram [16];
	logic cmd_req = 1'b0;
	logic cmd_we = 1'b0;
	logic [31:0] cmd_addr = 32'h0;
	logic [31:0] cmd_wdata = 32'h0;
	logic done, miss, pbusy, num_ok;
	logic [31:0] rdata, present;
	logic probe = 1'b0;
	logic [2:0] largest = 3'h0;
	logic [4:0] total = 5'h01;
	logic [4:0] own = 5'h00;
	logic first = 1'b0;
	logic [2:0] size;
	int fails = 0;
	int checked = 0;

	always #2 mclk_in = ~mclk_in;

	vswm_if vswm_if_i ();

	vswm_board_end vswm_board_end_i (.mclk_in(mclk_in), .resetn_in(resetn_in), .bus(vswm_if_i.board),
		.board_num_in(brd_num), .win_size_in(brd_sz), .region_base_in(brd_base),
		.mem_req_out(mem_req), .mem_we_out(mem_we), .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata),
		.mem_rdata_in(dram[mem_addr[5:2]]), .cfg_ready_out(cfg_ready), .cfg_err_out(cfg_err),
		.win0_ctrl_out(w0_ctrl), .win0_start_out(w0_start), .win0_bound_out(w0_bound),
		.win0_offset_out(w0_off), .win0_en_out(w0_en), .win1_start_out(w1_start),
		.win1_bound_out(w1_bound), .win1_en_out(w1_en));

	vswm_peer_end vswm_peer_end_i (.mclk_in(mclk_in), .resetn_in(resetn_in), .bus(vswm_if_i.peer),
		.cmd_req_in(cmd_req), .cmd_we_in(cmd_we), .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata),
		.cmd_done_out(done), .cmd_miss_out(miss), .cmd_rdata_out(rdata),
		.probe_start_in(probe), .probe_base_in(brd_base), .probe_busy_out(pbusy), .present_out(present),
		.largest_dram_in(largest), .board_total_in(total), .own_num_in(own), .first_slot_in(first),
		.win_size_out(size), .own_num_ok_out(num_ok));

	vswm_props vswm_props_i (.mclk_in(mclk_in), .resetn_in(resetn_in), .req(vswm_if_i.req),
		.we(vswm_if_i.we), .addr(vswm_if_i.addr), .wdata(vswm_if_i.wdata), .ack(vswm_if_i.ack),
		.rdata(vswm_if_i.rdata));

	// Small memory behind the board, read combinationally from mem_addr, written on the edge that ends a request
	always @(posedge mclk_in) begin
		if (mem_req && mem_we)
			dram[mem_addr[5:2]] <= mem_wdata;
	end

	task end_sim;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task rst;
		@(posedge mclk_in);
		resetn_in <= 1'b0;
		repeat (10) @(posedge mclk_in);
		resetn_in <= 1'b1;
		repeat (8) @(posedge mclk_in);
		@(negedge mclk_in);
	endtask : rst

	// Request is dropped after the taking edge; the peer holds its own copy
	task cmd(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_in);
		cmd_req <= 1'b1;
		cmd_we <= w;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge mclk_in);
		cmd_req <= 1'b0;
		do begin
			@(negedge mclk_in);
			n++;
		end while (done !== 1'b1 && n < 40);
		if (n >= 40) begin
			fails++;
			end_sim();
		end
	endtask : cmd

	task t_cfg_good;
		chk(w0_ctrl, 32'h80f2_0001);
		chk(w0_start, 32'heffc_6000);
		chk(w0_bound, 32'heffc_8000);
		chk(w0_off, 32'h1003_a000);
		chk({28'h0, cfg_ready, cfg_err, w0_en, w1_en}, 32'hb);
		chk(w1_start, 32'h3000_0000);
		chk(w1_bound, 32'h4000_0000);
	endtask : t_cfg_good

	task t_reg;
		cmd(1'b1, 32'heffc_6004, 32'ha5a5_0001);
		cmd(1'b1, 32'heffc_6000, 32'hffff_ffff);
		cmd(1'b1, 32'heffc_7ffc, 32'h1111_2222);
		cmd(1'b0, 32'heffc_6004, 32'h0);
		chk(rdata, 32'ha5a5_0001);
		chk({31'h0, miss}, 32'h0);
		cmd(1'b0, 32'heffc_6000, 32'h0);
		chk(rdata, 32'h0000_0043);
		cmd(1'b0, 32'heffc_7ffc, 32'h0);
		chk(rdata, 32'h0);
	endtask : t_reg

	task t_dram;
		cmd(1'b1, 32'h3000_0010, 32'h1234_5678);
		chk(mem_addr, 32'h0000_0010);
		cmd(1'b1, 32'h3fff_fffc, 32'h9abc_def0);
		chk(mem_addr, 32'h0fff_fffc);
		cmd(1'b0, 32'h3000_0010, 32'h0);
		chk(rdata, 32'h1234_5678);
		cmd(1'b0, 32'h3fff_fffc, 32'h0);
		chk(rdata, 32'h9abc_def0);
	endtask : t_dram

	task t_miss;
		logic [31:0] a [4] = '{32'h4000_0000, 32'h2fff_fffc, 32'heffc_4000, 32'heffc_8000};
		for (int i = 0; i < 4; i++) begin
			cmd(1'b0, a[i], 32'h0);
			chk({31'h0, miss}, 32'h1);
		end
	endtask : t_miss

	task t_probe;
		int n;
		n = 0;
		@(posedge mclk_in);
		probe <= 1'b1;
		@(posedge mclk_in);
		probe <= 1'b0;
		do begin
			@(negedge mclk_in);
			n++;
		end while (pbusy === 1'b1 && n < 3000);
		if (n >= 3000) begin
			fails++;
			end_sim();
		end
		chk(present, 32'h0000_0008);
	endtask : t_probe

	task t_size;
		logic [2:0] lg [8] = '{3'h4, 3'h3, 3'h0, 3'h2, 3'h0, 3'h1, 3'h0, 3'h0};
		logic [4:0] tot [8] = '{5'h02, 5'h0a, 5'h04, 5'h14, 5'h08, 5'h14, 5'h10, 5'h11};
		logic [2:0] ex [8] = '{3'h4, 3'h3, 3'h3, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0};
		logic fo [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
		logic [4:0] on [4] = '{5'h14, 5'h15, 5'h00, 5'h00};
		logic ok [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk_in);
			largest <= lg[i];
			total <= tot[i];
			repeat (2) @(negedge mclk_in);
			chk({29'h0, size}, {29'h0, ex[i]});
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk_in);
			first <= fo[i];
			own <= on[i];
			repeat (3) @(negedge mclk_in);
			chk({31'h0, num_ok}, {31'h0, ok[i]});
		end
	endtask : t_size

	// Base outside the programmed-I/O window and a window too large for board 3
	task t_cfg_bad;
		@(posedge mclk_in);
		brd_base <= 32'h8000_0000;
		brd_sz <= 3'h4;
		rst();
		chk({29'h0, cfg_err, w0_en, w1_en}, 32'h4);
		chk(w0_ctrl, 32'h80f2_0001);
	endtask : t_cfg_bad

	initial begin
		rst();
		t_cfg_good();
		t_reg();
		t_dram();
		t_miss();
		t_probe();
		t_size();
		t_cfg_bad();
		end_sim();
	end
endmodule : vme_slave_window_map_tb
